// *** hw/pic_defines.vh ***
// Functional notes
// - latch flags for errors, rejects, inhibit, counter
// - interrupt low when flag and mask set
// - bit 0 on enabled transmit-data parity error
// - check all transmitter-bound data, not pass-through
// - bit 1 on enabled management write parity mismatch
// - conditional write skips changed bits, sets bit 3
// - bit 4 when link counter hits zero, reset
// - summary bits follow masked receive conditions
// - bit 7 follows any user sense bit
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
// ==========================================================
// register map
`define PIC_ADDR_INTR_COND   8'h02
`define PIC_ADDR_INTR_MASK   8'h03
`define PIC_ADDR_INTR_CMP    8'h1A
`define PIC_ADDR_DEV_ID      8'h18
`define PIC_ADDR_LINK_COUNT  8'h16
// ==========================================================
// field positions of the interrupt condition register
`define PIC_BIT_DPE   0
`define PIC_BIT_CPE   1
`define PIC_BIT_WREJ  2
`define PIC_BIT_CWI   3
`define PIC_BIT_LINK_ERROR_THRESHOLD_FLAG  4
`define PIC_BIT_RCA   5
`define PIC_BIT_RCB   6
`define PIC_BIT_UDI   7
// ==========================================================
// reset values
`define PIC_COND_RST  8'h10
`define PIC_MASK_RST  8'h00
`define PIC_ZERO8     8'h00
`endif

// *** hw/pic_parity_chk.v ***
`timescale 1ns/1ps
`include "pic_defines.vh"
// parity checker, odd or even as odd_i selects, over a data byte and its parity bit
module pic_parity_chk #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] data_i,
  input  wire             parity_i,
  input  wire             odd_i,
  output wire             error_o
);
  // ==========================================================
  // mismatch when total ones disagree with chosen sense
  assign error_o = (^{data_i, parity_i}) ^ odd_i;
endmodule // pic_parity_chk

// *** hw/pic_intr_cond.v ***
`timescale 1ns/1ps
`include "pic_defines.vh"
// interrupt condition register, mask, compare and interrupt pin
module pic_intr_cond #(
  parameter DW = 8
) (
  input  wire          CLOCK_I,
  input  wire          SRST_I,
  // management bus, one-cycle strobes
  input  wire [7:0]    MGMT_ADDR_I,
  input  wire [DW-1:0] MGMT_BUS_DATA_I,
  input  wire          MGMT_BUS_PARITY_I,
  input  wire          MGMT_WR_I,
  input  wire          MGMT_RD_I,
  input  wire          MGMT_PAR_EN_I,
  input  wire          MGMT_READ_ONLY_I,
  output reg  [DW-1:0] MGMT_RDATA_O,
  // transmit data path
  input  wire [DW-1:0] TX_DATA_I,
  input  wire          TX_PARITY_I,
  input  wire          TX_VALID_I,
  input  wire          TX_TO_TRANSMITTER_I,
  input  wire          REQ_PAR_EN_I,
  // event sources
  input  wire          LINK_ERR_ZERO_I,
  input  wire          CWI_EXT_I,
  input  wire [DW-1:0] RECEIVE_CONDITION_REG_A_I,
  input  wire [DW-1:0] RECEIVE_MASK_REG_A_I,
  input  wire [DW-1:0] RECEIVE_CONDITION_REG_B_I,
  input  wire [DW-1:0] RECEIVE_MASK_REG_B_I,
  input  wire [2:0]    USER_SENSE_I,
  output reg           INTR_N_O,
  output reg  [DW-1:0] INTERRUPT_CONDITION_O
);
  reg  [DW-1:0] cond_r;
  reg  [DW-1:0] cond_nxt;
  reg  [DW-1:0] mask_r;
  reg  [DW-1:0] cmp_r;
  reg  [DW-1:0] keep;
  wire          mgmt_perr;
  wire          tx_perr;
  wire          wr_ok;
  wire          wr_cond;

  // ==========================================================
  // parity checkers; error when data plus parity bit holds an odd count of ones
  pic_parity_chk #(.WIDTH(DW)) u_mgmt_par (
    .data_i   (MGMT_BUS_DATA_I),
    .parity_i (MGMT_BUS_PARITY_I),
    .odd_i    (1'b0),
    .error_o  (mgmt_perr)
  );
  pic_parity_chk #(.WIDTH(DW)) u_tx_par (
    .data_i   (TX_DATA_I),
    .parity_i (TX_PARITY_I),
    .odd_i    (1'b0),
    .error_o  (tx_perr)
  );

  // with MGMT_PAR_EN_I set, a bad-parity write is dropped so corrupt data never lands
  assign wr_ok   = MGMT_WR_I & ~(MGMT_PAR_EN_I & mgmt_perr) & ~MGMT_READ_ONLY_I;
  assign wr_cond = wr_ok & (MGMT_ADDR_I == `PIC_ADDR_INTR_COND);

  // ==========================================================
  // next value of the condition register
  always @* begin
    cond_nxt = cond_r;
    keep     = `PIC_ZERO8;
    // conditional write: only bits unchanged since last read may clear
    if (wr_cond) begin
      keep     = ~(cond_r ^ cmp_r);
      cond_nxt = (cond_r & ~keep) | (MGMT_BUS_DATA_I & keep & cond_r);
    end
    // sources set after the write so set wins over clear
    if (REQ_PAR_EN_I & TX_VALID_I & TX_TO_TRANSMITTER_I & tx_perr) begin
      cond_nxt[`PIC_BIT_DPE] = 1'b1;
    end
    if (MGMT_WR_I & MGMT_PAR_EN_I & mgmt_perr) begin
      cond_nxt[`PIC_BIT_CPE] = 1'b1;
    end
    if (MGMT_WR_I & MGMT_READ_ONLY_I) begin
      cond_nxt[`PIC_BIT_WREJ] = 1'b1;
    end
    if ((wr_cond & (|(MGMT_BUS_DATA_I & ~keep & cond_r) | |(~MGMT_BUS_DATA_I & ~keep))) | CWI_EXT_I) begin
      cond_nxt[`PIC_BIT_CWI] = 1'b1;
    end
    if (LINK_ERR_ZERO_I) begin
      cond_nxt[`PIC_BIT_LINK_ERROR_THRESHOLD_FLAG] = 1'b1;
    end
    // level-following summaries, not clearable by software
    cond_nxt[`PIC_BIT_RCA] = |(RECEIVE_CONDITION_REG_A_I & RECEIVE_MASK_REG_A_I);
    cond_nxt[`PIC_BIT_RCB] = |(RECEIVE_CONDITION_REG_B_I & RECEIVE_MASK_REG_B_I);
    cond_nxt[`PIC_BIT_UDI] = |USER_SENSE_I;
  end

  // ==========================================================
  // registers; link counter resets to zero so threshold sets
  always @(posedge CLOCK_I) begin
    if (SRST_I) begin
      cond_r                <= `PIC_COND_RST;
      mask_r                <= `PIC_MASK_RST;
      cmp_r                 <= `PIC_ZERO8;
      INTR_N_O              <= 1'b1;
      MGMT_RDATA_O          <= `PIC_ZERO8;
      INTERRUPT_CONDITION_O <= `PIC_COND_RST;
    end else begin
      cond_r <= cond_nxt;
      if (wr_ok & (MGMT_ADDR_I == `PIC_ADDR_INTR_MASK)) begin
        mask_r <= MGMT_BUS_DATA_I;
      end
      // a read of the condition register snapshots it into the compare register
      if (MGMT_RD_I & (MGMT_ADDR_I == `PIC_ADDR_INTR_COND)) begin
        cmp_r <= cond_r;
      end
      if (MGMT_RD_I) begin
        case (MGMT_ADDR_I)
          `PIC_ADDR_INTR_COND: MGMT_RDATA_O <= cond_r;
          `PIC_ADDR_INTR_MASK: MGMT_RDATA_O <= mask_r;
          `PIC_ADDR_INTR_CMP:  MGMT_RDATA_O <= cmp_r;
          default:             MGMT_RDATA_O <= `PIC_ZERO8;
        endcase
      end
      INTR_N_O              <= ~|(cond_nxt & mask_r);
      INTERRUPT_CONDITION_O <= cond_nxt;
    end
  end
endmodule // pic_intr_cond

// *** test/pic_chk_properties.sv ***
`timescale 1ns/1ps
// ==========
// flag checks at the pins
module pic_chk(input wire logic CLOCK_I, SRST_I, MGMT_BUS_PARITY_I, MGMT_WR_I, MGMT_PAR_EN_I,
  MGMT_READ_ONLY_I, TX_PARITY_I, TX_VALID_I, TX_TO_TRANSMITTER_I, REQ_PAR_EN_I,
  LINK_ERR_ZERO_I, CWI_EXT_I, INTR_N_O, input wire logic [7:0] MGMT_BUS_DATA_I, TX_DATA_I,
  INTERRUPT_CONDITION_O, input wire logic [2:0] USER_SENSE_I);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  wire logic [7:0] c = INTERRUPT_CONDITION_O;
  // two quiet cycles tolerate either pin timing
  property p_irq; c == 0 ##1 c == 0 |-> INTR_N_O; endproperty
  property p_dpe; TX_VALID_I && TX_TO_TRANSMITTER_I && REQ_PAR_EN_I
    && ^{TX_DATA_I, TX_PARITY_I} |=> c[0]; endproperty
  property p_thru; TX_VALID_I && !TX_TO_TRANSMITTER_I && !c[0] |=> !c[0]; endproperty
  property p_cpe; MGMT_WR_I && MGMT_PAR_EN_I && ^{MGMT_BUS_DATA_I, MGMT_BUS_PARITY_I}
    |=> c[1]; endproperty
  property p_rej; MGMT_WR_I && MGMT_READ_ONLY_I |=> c[2]; endproperty
  property p_cwi; CWI_EXT_I |=> c[3]; endproperty
  property p_link_error_threshold_flag; LINK_ERR_ZERO_I |=> c[4]; endproperty
  property p_udi; !$past(SRST_I) |-> c[7] == $past(|USER_SENSE_I); endproperty
  a_irq: assert property (p_irq) else $error("pin low with no flag");
  a_dpe: assert property (p_dpe) else $error("transmit parity flag");
  a_thru: assert property (p_thru) else $error("pass-through flagged");
  a_cpe: assert property (p_cpe) else $error("bus parity flag");
  a_rej: assert property (p_rej) else $error("reject flag");
  a_cwi: assert property (p_cwi) else $error("inhibit flag");
  a_link_error_threshold_flag: assert property (p_link_error_threshold_flag) else $error("threshold flag");
  a_udi: assert property (p_udi) else $error("sense flag");
  cover property (c[0]);
  cover property (c[1] && !INTR_N_O);
  cover property (c[3]);
endmodule // pic_chk
bind pic_intr_cond pic_chk i_pic_chk(.*);

// *** test/pic_host.sv ***
`timescale 1ns/1ps
// host on the management bus, one-cycle strobes
module pic_host(input wire logic CLOCK_I, output logic [7:0] MGMT_ADDR_I, MGMT_BUS_DATA_I,
  output logic MGMT_BUS_PARITY_I, MGMT_WR_I, MGMT_RD_I);
  initial {MGMT_ADDR_I, MGMT_BUS_DATA_I, MGMT_BUS_PARITY_I, MGMT_WR_I, MGMT_RD_I} = 0;
  // released data inverts so stale bytes never look valid
  task acc(input logic w, input logic [7:0] a, d, input logic p);
    @(negedge CLOCK_I) {MGMT_WR_I, MGMT_RD_I, MGMT_ADDR_I, MGMT_BUS_DATA_I} = {w, !w, a, d};
    MGMT_BUS_PARITY_I = p;
    @(negedge CLOCK_I) {MGMT_WR_I, MGMT_RD_I, MGMT_BUS_DATA_I} = {2'b00, ~d};
  endtask
endmodule // pic_host

// *** test/pic_intr_cond_tb.sv ***
`timescale 1ns/1ps
module pic_intr_cond_tb;
  logic CLOCK_I = 0, SRST_I = 1, MGMT_PAR_EN_I = 1, MGMT_READ_ONLY_I = 0, TX_PARITY_I = 0,
    TX_VALID_I = 0, TX_TO_TRANSMITTER_I = 0, REQ_PAR_EN_I = 1, LINK_ERR_ZERO_I = 0,
    CWI_EXT_I = 0, MGMT_BUS_PARITY_I, MGMT_WR_I, MGMT_RD_I, INTR_N_O;
  logic [7:0] MGMT_ADDR_I, MGMT_BUS_DATA_I, MGMT_RDATA_O, INTERRUPT_CONDITION_O, TX_DATA_I = 0,
    RECEIVE_CONDITION_REG_A_I = 0, RECEIVE_MASK_REG_A_I = 0, RECEIVE_CONDITION_REG_B_I = 0,
    RECEIVE_MASK_REG_B_I = 0;
  logic [2:0] USER_SENSE_I = 0;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #2.5 CLOCK_I = ~CLOCK_I;
  pic_intr_cond i_pic_intr_cond(.*);
  pic_host i_pic_host(.*);
  task chk(input string s, input logic [7:0] v, e);
    total_checks++;
    if (v !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, v);
    end
  endtask
  // read then write zero clears unchanged sticky bits
  task clr;
    i_pic_host.acc(0, 2, 0, 0);
    i_pic_host.acc(1, 2, 0, 0);
  endtask
  task t_cond;
    chk("intr", INTR_N_O, 1);
    i_pic_host.acc(0, 2, 0, 0);
    chk("rd", MGMT_RDATA_O, 8'h10);
    i_pic_host.acc(1, 2, 0, 0);
    chk("clr", INTERRUPT_CONDITION_O, 0);
    i_pic_host.acc(0, 2, 0, 0);
    LINK_ERR_ZERO_I = 1;
    @(negedge CLOCK_I) LINK_ERR_ZERO_I = 0;
    i_pic_host.acc(1, 2, 0, 0);
    chk("cwi", INTERRUPT_CONDITION_O, 8'h18);
  endtask
  task t_refuse;
    clr;
    i_pic_host.acc(1, 3, 8'hFF, 0);
    i_pic_host.acc(1, 3, 8'h01, 0);
    chk("cpe", INTERRUPT_CONDITION_O, 8'h02);
    @(negedge CLOCK_I) chk("int", INTR_N_O, 0);
    i_pic_host.acc(0, 3, 0, 0);
    chk("mask", MGMT_RDATA_O, 8'hFF);
    MGMT_READ_ONLY_I = 1;
    i_pic_host.acc(1, 8'h18, 8'h01, 1);
    MGMT_READ_ONLY_I = 0;
    chk("rej", INTERRUPT_CONDITION_O, 8'h06);
  endtask
  task t_tx;
    clr;
    TX_DATA_I = 8'h01;
    TX_VALID_I = 1;
    @(negedge CLOCK_I) TX_TO_TRANSMITTER_I = 1;
    chk("thru", INTERRUPT_CONDITION_O, 0);
    @(negedge CLOCK_I) TX_VALID_I = 0;
    chk("dpe", INTERRUPT_CONDITION_O, 1);
  endtask
  task t_follow;
    clr;
    {RECEIVE_CONDITION_REG_A_I, RECEIVE_CONDITION_REG_B_I, RECEIVE_MASK_REG_B_I} = 24'h04_4080;
    USER_SENSE_I = 3'h4;
    @(negedge CLOCK_I) {RECEIVE_MASK_REG_A_I, RECEIVE_MASK_REG_B_I} = 16'h0440;
    chk("low", INTERRUPT_CONDITION_O, 8'h80);
    @(negedge CLOCK_I) {USER_SENSE_I, RECEIVE_CONDITION_REG_A_I} = 0;
    chk("set", INTERRUPT_CONDITION_O, 8'hE0);
    @(negedge CLOCK_I) chk("drop", INTERRUPT_CONDITION_O, 8'h40);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far beyond the forty or so cycles used
  always @(posedge CLOCK_I) if (++cyc > 2000) begin
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (2) @(negedge CLOCK_I);
    SRST_I = 0;
    t_cond;
    t_refuse;
    t_tx;
    t_follow;
    wrap_up;
  end
endmodule // pic_intr_cond_tb
